// ### cie_defines.svh
// cie_defines.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by cie_pkg.sv; cie_core.sv uses its macros without including it
`ifndef CIE_DEFINES_SVH
`define CIE_DEFINES_SVH
// data memory map of the special registers
`define CIE_ADDR_WORKING   8'h0a
`define CIE_ADDR_ALU_FLAG  8'h04
`define CIE_ADDR_PC_LOW    8'h02
`define CIE_ADDR_PC_LATCH  8'h03
// flag bit positions inside the alu flag register
`define CIE_FLAG_CARRY     0
`define CIE_FLAG_HALF      1
`define CIE_FLAG_ZERO      2
`define CIE_FLAG_WRAP      3
// opcode fields
`define CIE_OP_ADDC        7'h08
`define CIE_OP_ANDL        8'hb5
`define CIE_OP_CLEAR_FILE_INSTR        7'h14
`define CIE_OP_BSET        5'h11
`define CIE_OP_BCLR        5'h10
`define CIE_OP_BTOG        5'h07
`define CIE_OP_MOVF        7'h1c
`define CIE_OP_MOVWF       8'h01
// reset values
`define CIE_RST_BYTE       8'h00
`define CIE_RST_OPCODE     16'h0000
// phases in one instruction cycle
`define CIE_PHASES         4
`endif

// ### cie_pkg.sv
// cie_pkg.sv: types of the instruction execute core
// assumes cie_defines.svh lies beside it
`default_nettype none
package cie_pkg;
    `include "cie_defines.svh"

    typedef enum logic [3:0] {
        CIE_Q1 = 4'b0001,
        CIE_Q2 = 4'b0010,
        CIE_Q3 = 4'b0100,
        CIE_Q4 = 4'b1000
    } cie_phase_t;

    typedef enum logic [6:0] {
        CIE_K_NOP  = 7'b0000001,
        CIE_K_ADDC = 7'b0000010,
        CIE_K_ANDL = 7'b0000100,
        CIE_K_CLEAR_FILE_INSTR = 7'b0001000,
        CIE_K_BIT  = 7'b0010000,
        CIE_K_MOVF = 7'b0100000,
        CIE_K_MOVW = 7'b1000000
    } cie_kind_t;

    // data memory access toward the file registers
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cie_dmem_t;

    // alu flags
    typedef struct packed {
        logic wrap;
        logic zero;
        logic half;
        logic carry;
    } cie_flags_t;
endpackage : cie_pkg
`default_nettype wire

// ### cie_core.sv
// cie_core.sv: four-phase instruction execute core of an 8-bit controller
// assumes program memory holds opcode steady through q1 and data memory
// answers a read in the same phase as rd
// Operation
// - writes to flag register are overridden only in the flag bits the instruction itself updates; bit ops and movwf keep the written value
// - pc low read latches high byte; pc low write loads high from latch
// - bit set, clear, toggle read whole register and write all bits back
// - every instruction cycle is exactly four consecutive phases
// - q1 decode or nop, q2 read, q3 execute, q4 write or nop
// - add with carry sums working, file and carry, d selects destination
// - and literal ands working with literal, sets only zero flag
`default_nettype none
module cie_core
    import cie_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // program memory
    input  wire logic [15:0] opcode,
    input  wire logic        force_nop,
    output logic             fetch_next,
    // data memory
    input  wire logic [7:0]  dmem_rdata,
    output cie_dmem_t        dmem,
    // visible state
    output cie_phase_t       phase,
    output logic [7:0]       working_register,
    output logic [7:0]       alu_flag_register,
    output logic [7:0]       pc_low_byte,
    output logic [7:0]       pc_high_internal,
    output logic [7:0]       pc_high_latch
);
    cie_phase_t       phase_reg;
    cie_kind_t        kind_reg;
    logic [15:0]      op_reg;
    logic [7:0]       opnd_reg;
    logic [7:0]       res_reg;
    logic             res_to_w_reg;
    logic             res_valid_reg;
    cie_flags_t       flg_reg;
    logic [3:0]       flg_mask_reg;
    logic [7:0]       w_reg;
    logic [7:0]       alu_reg;
    logic [7:0]       pcl_reg;
    logic [7:0]       pch_reg;
    logic [7:0]       pc_high_latch_reg;
    cie_dmem_t        dmem_reg;
    logic             fetch_reg;

    logic [7:0]       faddr;
    logic [7:0]       src_val;
    logic [8:0]       sum;
    logic [4:0]       nib;
    logic [7:0]       bitmask;
    logic [7:0]       bitres;
    logic [7:0]       andres;
    logic [7:0]       res_next;
    logic             res_to_w_next;
    logic             res_valid_next;
    cie_flags_t       flg_next;
    logic [3:0]       flg_mask_next;

    assign faddr   = op_reg[7:0];
    assign bitmask = 8'h01 << op_reg[10:8];
    // special registers are served inside the core, others from memory
    always_comb begin
        if (faddr == `CIE_ADDR_WORKING) begin
            src_val = w_reg;
        end else if (faddr == `CIE_ADDR_ALU_FLAG) begin
            src_val = alu_reg;
        end else if (faddr == `CIE_ADDR_PC_LOW) begin
            src_val = pcl_reg;
        end else if (faddr == `CIE_ADDR_PC_LATCH) begin
            src_val = pc_high_latch_reg;
        end else begin
            src_val = dmem_rdata;
        end
    end
    assign sum    = {1'b0, w_reg} + {1'b0, opnd_reg}
                  + {8'h00, alu_reg[`CIE_FLAG_CARRY]};
    assign nib    = {1'b0, w_reg[3:0]} + {1'b0, opnd_reg[3:0]}
                  + {4'h0, alu_reg[`CIE_FLAG_CARRY]};
    assign andres = w_reg & op_reg[7:0];
    always_comb begin
        if (op_reg[15:11] == `CIE_OP_BSET) begin
            bitres = opnd_reg | bitmask;
        end else if (op_reg[15:11] == `CIE_OP_BCLR) begin
            bitres = opnd_reg & ~bitmask;
        end else begin
            bitres = opnd_reg ^ bitmask;
        end
    end

    // phase ring, never skips or stalls
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_reg <= CIE_Q1;
        end else begin
            case (phase_reg)
                CIE_Q1:  phase_reg <= CIE_Q2;
                CIE_Q2:  phase_reg <= CIE_Q3;
                CIE_Q3:  phase_reg <= CIE_Q4;
                default: phase_reg <= CIE_Q1;
            endcase
        end
    end

    // q1 decode; reserved opcodes fall to nop by choice, not by promise
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            kind_reg <= CIE_K_NOP;
            op_reg   <= `CIE_RST_OPCODE;
        end else if (phase_reg == CIE_Q1) begin
            op_reg <= opcode;
            if (force_nop) begin
                kind_reg <= CIE_K_NOP;
            end else if (opcode[15:9] == `CIE_OP_ADDC) begin
                kind_reg <= CIE_K_ADDC;
            end else if (opcode[15:8] == `CIE_OP_ANDL) begin
                kind_reg <= CIE_K_ANDL;
            end else if (opcode[15:9] == `CIE_OP_CLEAR_FILE_INSTR) begin
                kind_reg <= CIE_K_CLEAR_FILE_INSTR;
            end else if (opcode[15:9] == `CIE_OP_MOVF) begin
                // ahead of the toggle test: both share the top five bits
                kind_reg <= CIE_K_MOVF;
            end else if (opcode[15:11] == `CIE_OP_BSET
                      || opcode[15:11] == `CIE_OP_BCLR
                      || opcode[15:11] == `CIE_OP_BTOG) begin
                kind_reg <= CIE_K_BIT;
            end else if (opcode[15:8] == `CIE_OP_MOVWF) begin
                kind_reg <= CIE_K_MOVW;
            end else begin
                kind_reg <= CIE_K_NOP;
            end
        end
    end

    // data memory strobes: read issued in q2, write in q4
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dmem_reg <= '0;
        end else begin
            dmem_reg.rd <= 1'b0;
            dmem_reg.wr <= 1'b0;
            if (phase_reg == CIE_Q1 && !force_nop) begin
                dmem_reg.addr <= opcode[7:0];
                dmem_reg.rd   <= 1'b1;
            end else if (phase_reg == CIE_Q3 && res_valid_next) begin
                dmem_reg.wr    <= !res_to_w_next;
                dmem_reg.wdata <= res_next;
            end
        end
    end

    // q2 operand read; a pc low read copies the high byte to the latch
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            opnd_reg <= `CIE_RST_BYTE;
        end else if (phase_reg == CIE_Q2) begin
            opnd_reg <= src_val;
        end
    end

    // q3 execute
    always_comb begin
        res_next       = `CIE_RST_BYTE;
        res_to_w_next  = 1'b0;
        res_valid_next = 1'b0;
        flg_next       = '0;
        flg_mask_next  = 4'h0;
        case (kind_reg)
            CIE_K_ADDC: begin
                res_next       = sum[7:0];
                res_to_w_next  = !op_reg[8];
                res_valid_next = 1'b1;
                flg_next.carry = sum[8];
                flg_next.half  = nib[4];
                flg_next.zero  = (sum[7:0] == 8'h00);
                flg_next.wrap  = (w_reg[7] == opnd_reg[7])
                               && (sum[7] != w_reg[7]);
                flg_mask_next  = 4'hf;
            end
            CIE_K_ANDL: begin
                res_next       = andres;
                res_to_w_next  = 1'b1;
                res_valid_next = 1'b1;
                flg_next.zero  = (andres == 8'h00);
                flg_mask_next  = 4'h4;
            end
            CIE_K_CLEAR_FILE_INSTR: begin
                res_next       = 8'h00;
                res_to_w_next  = (faddr == `CIE_ADDR_WORKING);
                res_valid_next = 1'b1;
                flg_next.zero  = 1'b1;
                flg_mask_next  = 4'h4;
            end
            CIE_K_BIT: begin
                res_next       = bitres;
                res_to_w_next  = (faddr == `CIE_ADDR_WORKING);
                res_valid_next = 1'b1;
            end
            CIE_K_MOVF: begin
                res_next       = opnd_reg;
                res_to_w_next  = !op_reg[8];
                res_valid_next = 1'b1;
                flg_next.zero  = (opnd_reg == 8'h00);
                flg_mask_next  = 4'h4;
            end
            CIE_K_MOVW: begin
                res_next       = w_reg;
                res_to_w_next  = (faddr == `CIE_ADDR_WORKING);
                res_valid_next = 1'b1;
            end
            default: begin
                res_valid_next = 1'b0;
            end
        endcase
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            res_reg       <= `CIE_RST_BYTE;
            res_to_w_reg  <= 1'b0;
            res_valid_reg <= 1'b0;
            flg_reg       <= '0;
            flg_mask_reg  <= 4'h0;
        end else if (phase_reg == CIE_Q3) begin
            res_reg       <= res_next;
            res_to_w_reg  <= res_to_w_next;
            res_valid_reg <= res_valid_next;
            flg_reg       <= flg_next;
            flg_mask_reg  <= flg_mask_next;
        end
    end

    // q4 writeback of core-held registers
    logic wb;
    logic wb_file;
    assign wb      = phase_reg == CIE_Q4 && res_valid_reg;
    assign wb_file = wb && !res_to_w_reg;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            w_reg <= `CIE_RST_BYTE;
        end else if (wb && (res_to_w_reg
                 || faddr == `CIE_ADDR_WORKING)) begin
            w_reg <= res_reg;
        end
    end
    // flag result merges over any written value so it always wins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            alu_reg <= `CIE_RST_BYTE;
        end else if (phase_reg == CIE_Q4) begin
            alu_reg <= ((wb_file && faddr == `CIE_ADDR_ALU_FLAG)
                        ? res_reg : alu_reg)
                     & ~{4'h0, flg_mask_reg}
                     | ({4'h0, flg_reg} & {4'h0, flg_mask_reg});
        end
    end
    // program counter; the write goes through the latch for the high byte
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pcl_reg <= `CIE_RST_BYTE;
            pch_reg <= `CIE_RST_BYTE;
        end else if (phase_reg == CIE_Q4) begin
            if (wb_file && faddr == `CIE_ADDR_PC_LOW) begin
                pch_reg <= pc_high_latch_reg;
                pcl_reg <= res_reg;
            end else begin
                {pch_reg, pcl_reg} <= {pch_reg, pcl_reg} + 16'h0001;
            end
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pc_high_latch_reg <= `CIE_RST_BYTE;
        end else if (wb_file && faddr == `CIE_ADDR_PC_LATCH) begin
            pc_high_latch_reg <= res_reg;
        end else if (phase_reg == CIE_Q2 && kind_reg != CIE_K_NOP
                  && kind_reg != CIE_K_MOVW
                  && faddr == `CIE_ADDR_PC_LOW) begin
            // a plain move into pc low writes only, so the latch must stay
            pc_high_latch_reg <= pch_reg;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fetch_reg <= 1'b0;
        end else begin
            fetch_reg <= phase_reg == CIE_Q3;
        end
    end

    assign phase             = phase_reg;
    assign working_register  = w_reg;
    assign alu_flag_register = alu_reg;
    assign pc_low_byte       = pcl_reg;
    assign pc_high_internal  = pch_reg;
    assign pc_high_latch     = pc_high_latch_reg;
    assign dmem              = dmem_reg;
    assign fetch_next        = fetch_reg;

    // checks
    AST_PHASE_RING: assert property (@(posedge clk) disable iff (!rstn)
        phase_reg == CIE_Q1 |=> phase_reg == CIE_Q2 ##1 phase_reg == CIE_Q3
        ##1 phase_reg == CIE_Q4 ##1 phase_reg == CIE_Q1)
        else $error("phase ring broken");
    AST_WRITE_IN_Q4: assert property (@(posedge clk) disable iff (!rstn)
        dmem_reg.wr |-> phase_reg == CIE_Q4)
        else $error("memory write outside q4");
    AST_CLR_FLAG: assert property (@(posedge clk) disable iff (!rstn)
        phase_reg == CIE_Q3 && kind_reg == CIE_K_CLEAR_FILE_INSTR
        && faddr == `CIE_ADDR_ALU_FLAG |=> ##1 alu_reg == 8'h04)
        else $error("cleared flag register lacks zero");
    AST_PCL_WRITE: assert property (@(posedge clk) disable iff (!rstn)
        wb_file && faddr == `CIE_ADDR_PC_LOW
        |=> pch_reg == $past(pc_high_latch_reg) && pcl_reg == $past(res_reg))
        else $error("pc low write wrong");
    AST_ANDL: assert property (@(posedge clk) disable iff (!rstn)
        phase_reg == CIE_Q3 && kind_reg == CIE_K_ANDL
        |=> ##1 w_reg == $past(andres, 2)
        && alu_reg[3] == $past(alu_reg[3], 2))
        else $error("and literal wrong");
    AST_ADDC: assert property (@(posedge clk) disable iff (!rstn)
        phase_reg == CIE_Q3 && kind_reg == CIE_K_ADDC && !op_reg[8]
        |=> ##1 w_reg == $past(sum[7:0], 2))
        else $error("add with carry wrong");
    AST_BIT_WB: assert property (@(posedge clk) disable iff (!rstn)
        phase_reg == CIE_Q3 && kind_reg == CIE_K_BIT
        && faddr > 8'h0a |=> dmem_reg.wr
        && dmem_reg.wdata == $past(bitres))
        else $error("bit op write back wrong");
    AST_READ_Q2: assert property (@(posedge clk) disable iff (!rstn)
        dmem_reg.rd |-> phase_reg == CIE_Q2)
        else $error("memory read outside q2");
endmodule : cie_core
`default_nettype wire

// ### cie_mem_model.sv
// cie_mem_model.sv: data memory file registers seen by the execute core
// assumes rd pulses in q2 and wr pulses in q4, both sampled on clk rise
`default_nettype none
module cie_mem_model
    import cie_pkg::*;
(
    // clock
    input  wire logic       clk,
    // core access
    input  wire cie_dmem_t  dmem,
    output logic [7:0]      dmem_rdata
);
    logic [7:0] mem [256];
    logic [7:0] last_reg;

    // released bus shows the inverse of the last read, never a stale copy
    assign dmem_rdata = dmem.rd ? mem[dmem.addr] : ~last_reg;

    always_ff @(posedge clk) begin
        if (dmem.rd) begin
            last_reg <= mem[dmem.addr];
        end
    end

    always_ff @(posedge clk) begin
        if (dmem.wr) begin
            mem[dmem.addr] <= dmem.wdata;
        end
    end

    initial begin
        last_reg = 8'h00;
    end
endmodule : cie_mem_model
`default_nettype wire

// ### cpu_instruction_execute_tb_top.sv
// cpu_instruction_execute_tb_top.sv: self-checking bench of the core
// assumes cie_pkg compiled first; bench plays program memory itself
`default_nettype none
module cpu_instruction_execute_tb_top;
    import cie_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk;
    logic        rstn;
    logic [15:0] opcode;
    logic        force_nop;
    logic        fetch_next;
    logic [7:0]  dmem_rdata;
    cie_dmem_t   dmem;
    cie_phase_t  phase;
    logic [7:0]  working_register;
    logic [7:0]  alu_flag_register;
    logic [7:0]  pc_low_byte;
    logic [7:0]  pc_high_internal;
    logic [7:0]  pc_high_latch;
    int          n_errors;
    int          checked;
    logic        seen_rd;
    logic        seen_wr;
    logic [7:0]  rd_addr;
    logic [7:0]  seen_wd;
    logic [7:0]  ew;
    logic [7:0]  ef;

    cie_core i_dut (
        .clk              (clk),
        .rstn             (rstn),
        .opcode           (opcode),
        .force_nop        (force_nop),
        .fetch_next       (fetch_next),
        .dmem_rdata       (dmem_rdata),
        .dmem             (dmem),
        .phase            (phase),
        .working_register (working_register),
        .alu_flag_register(alu_flag_register),
        .pc_low_byte      (pc_low_byte),
        .pc_high_internal (pc_high_internal),
        .pc_high_latch    (pc_high_latch)
    );

    cie_mem_model i_mem (
        .clk       (clk),
        .dmem      (dmem),
        .dmem_rdata(dmem_rdata)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic results;
        $display("errors %0d, comparisons %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    // one whole instruction, entered at a falling edge inside q1
    task automatic exec(input logic [15:0] op, input logic nop_req);
        opcode = op;
        force_nop = nop_req;
        chk({4'h0, phase}, {4'h0, CIE_Q1});
        @(negedge clk);
        // opcode no longer held after the q1 edge
        opcode = ~op;
        force_nop = 1'b0;
        chk({4'h0, phase}, {4'h0, CIE_Q2});
        seen_rd = dmem.rd;
        rd_addr = dmem.addr;
        @(negedge clk);
        chk({4'h0, phase}, {4'h0, CIE_Q3});
        @(negedge clk);
        chk({4'h0, phase}, {4'h0, CIE_Q4});
        chk({7'h00, fetch_next}, 8'h01);
        seen_wr = dmem.wr;
        seen_wd = dmem.wdata;
        @(negedge clk);
    endtask : exec

    initial begin
        #20000;
        n_errors++;
        results();
    end

    initial begin
        logic [7:0] af [3];
        logic       ad [3];
        logic [7:0] lit [2];
        logic [4:0] bop [3];
        logic [2:0] bb [3];
        logic [8:0] s;
        logic [7:0] fv;
        logic [7:0] m;
        logic       h;
        logic       v;
        af = '{8'h21, 8'h22, 8'h24};
        ad = '{1'b1, 1'b0, 1'b1};
        lit = '{8'hf0, 8'h7f};
        bop = '{5'h11, 5'h10, 5'h07};
        bb = '{3'd1, 3'd2, 3'd7};
        n_errors = 0;
        checked = 0;
        rstn = 1'b0;
        opcode = 16'h0000;
        force_nop = 1'b0;
        repeat (2) @(negedge clk);
        chk({4'h0, phase}, {4'h0, CIE_Q1});
        chk(alu_flag_register, 8'h00);
        i_mem.mem[8'h20] = 8'h3c;
        i_mem.mem[8'h21] = 8'hc4;
        i_mem.mem[8'h22] = 8'h43;
        i_mem.mem[8'h23] = 8'h11;
        i_mem.mem[8'h24] = 8'h80;
        i_mem.mem[8'h25] = 8'h80;
        i_mem.mem[8'h30] = 8'ha5;
        rstn = 1'b1;
        // only listed opcodes are ever supplied
        exec({7'h1c, 1'b0, 8'h20}, 1'b0);
        chk({7'h00, seen_rd}, 8'h01);
        chk(rd_addr, 8'h20);
        chk(working_register, 8'h3c);
        ew = 8'h3c;
        exec({8'hb5, 8'h00}, 1'b1);
        chk(working_register, ew);
        chk({6'h00, seen_rd, seen_wr}, 8'h00);
        exec({7'h14, 1'b1, 8'h04}, 1'b0);
        chk(alu_flag_register, 8'h04);
        ef = 8'h04;
        for (int i = 0; i < 3; i++) begin
            fv = i_mem.mem[af[i]];
            s = {1'b0, ew} + {1'b0, fv} + {8'h00, ef[0]};
            h = ({1'b0, ew[3:0]} + {1'b0, fv[3:0]} + {4'h0, ef[0]}) > 5'h0f;
            v = (ew[7] == fv[7]) && (s[7] != ew[7]);
            ef = {ef[7:4], v, s[7:0] == 8'h00, h, s[8]};
            exec({7'h08, ad[i], af[i]}, 1'b0);
            if (ad[i]) begin
                chk({7'h00, seen_wr}, 8'h01);
                chk(i_mem.mem[af[i]], s[7:0]);
            end else begin
                ew = s[7:0];
            end
            chk(working_register, ew);
            chk(alu_flag_register, ef);
        end
        // carry and wrap stay set from the last sum
        for (int i = 0; i < 2; i++) begin
            ew = ew & lit[i];
            ef[2] = (ew == 8'h00);
            exec({8'hb5, lit[i]}, 1'b0);
            chk(working_register, ew);
            chk(alu_flag_register, ef);
        end
        m = i_mem.mem[8'h30];
        for (int i = 0; i < 3; i++) begin
            fv = 8'h01 << bb[i];
            m = (i == 0) ? (m | fv) : (i == 1) ? (m & ~fv) : (m ^ fv);
            exec({bop[i], bb[i], 8'h30}, 1'b0);
            chk({7'h00, seen_rd}, 8'h01);
            chk(seen_wd, m);
            chk(i_mem.mem[8'h30], m);
        end
        exec({7'h1c, 1'b0, 8'h25}, 1'b0);
        exec({8'h01, 8'h03}, 1'b0);
        chk(pc_high_latch, 8'h80);
        exec({8'h01, 8'h02}, 1'b0);
        chk(pc_low_byte, 8'h80);
        chk(pc_high_internal, 8'h80);
        exec({7'h1c, 1'b0, 8'h23}, 1'b0);
        exec({8'h01, 8'h03}, 1'b0);
        chk(pc_high_latch, 8'h11);
        exec({7'h1c, 1'b0, 8'h02}, 1'b0);
        chk(pc_high_latch, 8'h80);
        results();
    end
endmodule : cpu_instruction_execute_tb_top
`default_nettype wire
